// ---- tic_params.svh ----
`ifndef TIV_PARAMS_SVH
`define TIV_PARAMS_SVH

`define TIV_ADDR_CTRL      8'hA1
`define TIV_ADDR_SUBSEC    8'hA2
`define TIV_ADDR_SEC       8'hA3
`define TIV_ADDR_MIN       8'hA4
`define TIV_ADDR_HOUR      8'hA5
`define TIV_ADDR_MATCH     8'hA6

`define TIV_CTRL_RESET     8'h00
`define TIV_BIT_CLK_EN     0
`define TIV_BIT_CNT_EN     1
`define TIV_BIT_FLAG       2
`define TIV_BIT_SINGLE     3
`define TIV_BIT_TB_LO      4
`define TIV_BIT_TB_HI      5
`define TIV_BIT_H24        6
`define TIV_CTRL_WMASK     8'h7F

`define TIV_SUBSEC_MAX     8'h7F
`define TIV_SEC_MAX        8'h3B
`define TIV_MIN_MAX        8'h3B
`define TIV_HOUR_MAX_24    8'h17
`define TIV_HOUR_MAX_256   8'hFF
`define TIV_VECTOR         16'h0053

`define TIV_CLK_HZ         25000000
`define TIV_SUBSEC_PER_SEC 128
`define TIV_TICK_CYCLES    (`TIV_CLK_HZ / `TIV_SUBSEC_PER_SEC)

`endif

// ---- tic_pkg.sv ----
package tiv_pkg;

    typedef logic [7:0] tiv_byte_type;

    typedef enum logic [1:0] {
        TIV_TB_SUBSEC = 2'h0,
        TIV_TB_SEC    = 2'h1,
        TIV_TB_MIN    = 2'h2,
        TIV_TB_HOUR   = 2'h3
    } tiv_timebase_type;

endpackage

// ---- tic_wrap_counter.sv ----
`timescale 1ns/1ps
module tiv_wrap_counter (
    // Clock and reset
    input  wire logic                  clk_i,
    input  wire logic                  rst_n_i,
    // Control
    input  wire logic                  step_i,
    input  wire tiv_pkg::tiv_byte_type max_i,
    input  wire logic                  load_i,
    input  wire tiv_pkg::tiv_byte_type load_data_i,
    // Status
    output tiv_pkg::tiv_byte_type      count_o,
    output logic                       wrap_o
);
    import tiv_pkg::*;

    tiv_byte_type count_q;

    assign count_o = count_q;
    assign wrap_o  = step_i && (count_q >= max_i);

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            count_q <= 8'h00;
        end else if (load_i) begin
            count_q <= load_data_i;
        end else if (wrap_o) begin
            count_q <= 8'h00;
        end else if (step_i) begin
            count_q <= count_q + 8'h01;
        end
    end

endmodule

// ---- tic_top.sv ----
`timescale 1ns/1ps
`include "tic_params.svh"
module tiv_top #(
    parameter int TICK_CYCLES = `TIV_TICK_CYCLES
) (
    // Clock and power-on reset
    input  wire logic                  ref_clk_i,
    input  wire logic                  resetn_i,
    // Non-power-on core reset, synchronous
    input  wire logic                  core_rst_i,
    // Special function register port
    input  wire logic [7:0]            sfr_addr_i,
    input  wire logic                  sfr_wr_i,
    input  wire tiv_pkg::tiv_byte_type sfr_wdata_i,
    output tiv_pkg::tiv_byte_type      sfr_rdata_o,
    // Interrupt system
    input  wire logic                  irq_enable_i,
    input  wire logic                  irq_ack_i,
    input  wire logic                  power_down_i,
    output logic                       irq_o,
    output logic                       wake_o,
    output logic [15:0]                vector_o
);
    import tiv_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // Reset release
    logic rst_meta_q;
    logic rst_n_q;

    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            rst_meta_q <= 1'b0;
            rst_n_q    <= 1'b0;
        end else begin
            rst_meta_q <= 1'b1;
            rst_n_q    <= rst_meta_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // 1/128 second tick, free running through power-down
    logic [31:0] div_q;
    logic        tick_q;

    always_ff @(posedge ref_clk_i or negedge rst_n_q) begin
        if (!rst_n_q) begin
            div_q  <= 32'h0;
            tick_q <= 1'b0;
        end else if (div_q >= 32'(TICK_CYCLES - 1)) begin
            div_q  <= 32'h0;
            tick_q <= 1'b1;
        end else begin
            div_q  <= div_q + 32'h1;
            tick_q <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Register decode
    tiv_byte_type ctrl_q;
    tiv_byte_type match_q;
    logic         wr_ctrl;
    logic         wr_sub;
    logic         wr_sec;
    logic         wr_min;
    logic         wr_hour;

    assign wr_ctrl = sfr_wr_i && (sfr_addr_i == `TIV_ADDR_CTRL);
    assign wr_sub  = sfr_wr_i && (sfr_addr_i == `TIV_ADDR_SUBSEC);
    assign wr_sec  = sfr_wr_i && (sfr_addr_i == `TIV_ADDR_SEC);
    assign wr_min  = sfr_wr_i && (sfr_addr_i == `TIV_ADDR_MIN);
    assign wr_hour = sfr_wr_i && (sfr_addr_i == `TIV_ADDR_HOUR);

    ////////////////////////////////////////////////////////////////////////////
    // Time-keeping chain, counts kept through the core reset, which clears the 24-hour select
    logic         run;
    tiv_byte_type sub_cnt;
    tiv_byte_type sec_cnt;
    tiv_byte_type min_cnt;
    tiv_byte_type hour_cnt;
    tiv_byte_type hour_max;
    logic         sub_wrap;
    logic         sec_wrap;
    logic         min_wrap;
    logic         hour_wrap;

    assign run      = tick_q && ctrl_q[`TIV_BIT_CLK_EN];
    assign hour_max = ctrl_q[`TIV_BIT_H24] ? `TIV_HOUR_MAX_24 : `TIV_HOUR_MAX_256;

    tiv_wrap_counter u_subsec (
        .clk_i       (ref_clk_i),
        .rst_n_i     (rst_n_q),
        .step_i      (run),
        .max_i       (`TIV_SUBSEC_MAX),
        .load_i      (wr_sub),
        .load_data_i (sfr_wdata_i),
        .count_o     (sub_cnt),
        .wrap_o      (sub_wrap)
    );

    tiv_wrap_counter u_sec (
        .clk_i       (ref_clk_i),
        .rst_n_i     (rst_n_q),
        .step_i      (sub_wrap),
        .max_i       (`TIV_SEC_MAX),
        .load_i      (wr_sec),
        .load_data_i (sfr_wdata_i),
        .count_o     (sec_cnt),
        .wrap_o      (sec_wrap)
    );

    tiv_wrap_counter u_min (
        .clk_i       (ref_clk_i),
        .rst_n_i     (rst_n_q),
        .step_i      (sec_wrap),
        .max_i       (`TIV_MIN_MAX),
        .load_i      (wr_min),
        .load_data_i (sfr_wdata_i),
        .count_o     (min_cnt),
        .wrap_o      (min_wrap)
    );

    tiv_wrap_counter u_hour (
        .clk_i       (ref_clk_i),
        .rst_n_i     (rst_n_q),
        .step_i      (min_wrap),
        .max_i       (hour_max),
        .load_i      (wr_hour),
        .load_data_i (sfr_wdata_i),
        .count_o     (hour_cnt),
        .wrap_o      (hour_wrap)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Interval counter
    tiv_timebase_type tb_sel;
    logic             interval_step;
    logic             timeout;
    tiv_byte_type     interval_q;

    assign tb_sel = tiv_timebase_type'(ctrl_q[`TIV_BIT_TB_HI:`TIV_BIT_TB_LO]);

    always_comb begin
        case (tb_sel)
            TIV_TB_SUBSEC: interval_step = sub_wrap;
            TIV_TB_SEC:    interval_step = sec_wrap;
            TIV_TB_MIN:    interval_step = min_wrap;
            TIV_TB_HOUR:   interval_step = hour_wrap;
            default:       interval_step = 1'b0;
        endcase
    end

    // Full 8-bit count with minute base, stepped on each minute-counter wrap, gives the 256-hour reach
    assign timeout = ctrl_q[`TIV_BIT_CNT_EN] && interval_step
                     && ((interval_q + 8'h01) == match_q);

    always_ff @(posedge ref_clk_i or negedge rst_n_q) begin
        if (!rst_n_q) begin
            interval_q <= 8'h00;
        end else if (!ctrl_q[`TIV_BIT_CNT_EN] || timeout) begin
            interval_q <= 8'h00;
        end else if (interval_step) begin
            interval_q <= interval_q + 8'h01;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Control and match registers
    always_ff @(posedge ref_clk_i or negedge rst_n_q) begin
        if (!rst_n_q) begin
            ctrl_q <= `TIV_CTRL_RESET;
        end else if (core_rst_i) begin
            ctrl_q <= `TIV_CTRL_RESET | (ctrl_q & 8'h01);
        end else begin
            if (wr_ctrl) begin
                ctrl_q <= sfr_wdata_i & `TIV_CTRL_WMASK;
            end
            if (irq_ack_i) begin
                ctrl_q[`TIV_BIT_FLAG] <= 1'b0;
            end
            if (timeout) begin
                ctrl_q[`TIV_BIT_FLAG] <= 1'b1;
                if (ctrl_q[`TIV_BIT_SINGLE]) begin
                    ctrl_q[`TIV_BIT_CNT_EN] <= 1'b0;
                end
            end
        end
    end

    always_ff @(posedge ref_clk_i or negedge rst_n_q) begin
        if (!rst_n_q) begin
            match_q <= 8'h00;
        end else if (sfr_wr_i && (sfr_addr_i == `TIV_ADDR_MATCH)) begin
            match_q <= sfr_wdata_i;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Read data and interrupt outputs
    always_ff @(posedge ref_clk_i or negedge rst_n_q) begin
        if (!rst_n_q) begin
            sfr_rdata_o <= 8'h00;
        end else begin
            case (sfr_addr_i)
                `TIV_ADDR_CTRL:   sfr_rdata_o <= ctrl_q;
                `TIV_ADDR_SUBSEC: sfr_rdata_o <= sub_cnt;
                `TIV_ADDR_SEC:    sfr_rdata_o <= sec_cnt;
                `TIV_ADDR_MIN:    sfr_rdata_o <= min_cnt;
                `TIV_ADDR_HOUR:   sfr_rdata_o <= hour_cnt;
                `TIV_ADDR_MATCH:  sfr_rdata_o <= match_q;
                default:          sfr_rdata_o <= 8'h00;
            endcase
        end
    end

    always_ff @(posedge ref_clk_i or negedge rst_n_q) begin
        if (!rst_n_q) begin
            irq_o    <= 1'b0;
            wake_o   <= 1'b0;
            vector_o <= 16'h0000;
        end else begin
            irq_o    <= ctrl_q[`TIV_BIT_FLAG] && irq_enable_i;
            wake_o   <= ctrl_q[`TIV_BIT_FLAG] && irq_enable_i && power_down_i;
            vector_o <= `TIV_VECTOR;
        end
    end

endmodule

// ---- tic_top_checker.sv ----
`timescale 1ns/1ps
`include "tic_params.svh"
module tiv_top_checker #(
    parameter int TICK_CYCLES = `TIV_TICK_CYCLES
) (
    // Clock and resets
    input wire logic                  ref_clk_i,
    input wire logic                  resetn_i,
    input wire logic                  core_rst_i,
    // Register port
    input wire logic [7:0]            sfr_addr_i,
    input wire logic                  sfr_wr_i,
    input wire tiv_pkg::tiv_byte_type sfr_wdata_i,
    input wire tiv_pkg::tiv_byte_type sfr_rdata_o,
    // Interrupt system
    input wire logic                  irq_enable_i,
    input wire logic                  irq_ack_i,
    input wire logic                  power_down_i,
    input wire logic                  irq_o,
    input wire logic                  wake_o,
    input wire logic [15:0]           vector_o
);
    import tiv_pkg::*;

    default clocking dc @(posedge ref_clk_i);
    endclocking
    default disable iff (!resetn_i);

    a_vector_fixed: assert property ($past(resetn_i, 4) |-> vector_o == `TIV_VECTOR)
        else $error("service address wrong");
    a_irq_enable: assert property (!irq_enable_i |=> !irq_o)
        else $error("interrupt while disabled");
    a_wake_pd: assert property (!power_down_i |=> !wake_o)
        else $error("wake outside power-down");
    a_wake_cause: assert property (wake_o |-> irq_o && $past(power_down_i))
        else $error("wake without interrupt");
    a_flag_irq: assert property ($past(sfr_addr_i) == `TIV_ADDR_CTRL
        |-> irq_o == (sfr_rdata_o[`TIV_BIT_FLAG] && $past(irq_enable_i)))
        else $error("interrupt does not follow flag");
    a_bit7_zero: assert property ($past(sfr_addr_i) == `TIV_ADDR_CTRL |-> !sfr_rdata_o[7])
        else $error("reserved bit set");
    a_unmapped_zero: assert property (($past(sfr_addr_i) < `TIV_ADDR_CTRL
        || $past(sfr_addr_i) > `TIV_ADDR_MATCH) |-> sfr_rdata_o == 8'h00)
        else $error("unmapped read not zero");
    a_match_write: assert property ((sfr_wr_i && sfr_addr_i == `TIV_ADDR_MATCH
        && $past(resetn_i, 4)) ##1 (sfr_addr_i == `TIV_ADDR_MATCH && !sfr_wr_i)
        |=> sfr_rdata_o == $past(sfr_wdata_i, 2))
        else $error("match value not written");
endmodule
////////////////////////////////////////////////////////////////
bind tiv_top tiv_top_checker #(.TICK_CYCLES(TICK_CYCLES)) u_chk (
    .ref_clk_i    (ref_clk_i),
    .resetn_i     (resetn_i),
    .core_rst_i   (core_rst_i),
    .sfr_addr_i   (sfr_addr_i),
    .sfr_wr_i     (sfr_wr_i),
    .sfr_wdata_i  (sfr_wdata_i),
    .sfr_rdata_o  (sfr_rdata_o),
    .irq_enable_i (irq_enable_i),
    .irq_ack_i    (irq_ack_i),
    .power_down_i (power_down_i),
    .irq_o        (irq_o),
    .wake_o       (wake_o),
    .vector_o     (vector_o)
);

// ---- tic_tb_top.sv ----
`timescale 1ns/1ps
module time_interval_counter_tb_top;
    import tiv_pkg::*;
    logic          ref_clk_i = 1'b0;
    logic          resetn_i, core_rst_i, sfr_wr_i;
    logic [7:0]    sfr_addr_i;
    tiv_byte_type  sfr_wdata_i, sfr_rdata_o;
    logic          irq_enable_i, irq_ack_i, power_down_i, irq_o, wake_o, seen;
    logic [15:0]   vector_o;
    logic [7:0]    maxv [4] = '{8'h7F, 8'h3B, 8'h3B, 8'hFF};
    int            num_errors = 0;
    int            comparisons = 0;
    int            cycles = 0;

    tiv_top #(.TICK_CYCLES(4)) uut (
        .ref_clk_i    (ref_clk_i),
        .resetn_i     (resetn_i),
        .core_rst_i   (core_rst_i),
        .sfr_addr_i   (sfr_addr_i),
        .sfr_wr_i     (sfr_wr_i),
        .sfr_wdata_i  (sfr_wdata_i),
        .sfr_rdata_o  (sfr_rdata_o),
        .irq_enable_i (irq_enable_i),
        .irq_ack_i    (irq_ack_i),
        .power_down_i (power_down_i),
        .irq_o        (irq_o),
        .wake_o       (wake_o),
        .vector_o     (vector_o)
    );

    always #20 ref_clk_i = ~ref_clk_i;
    always @(posedge ref_clk_i) begin
        cycles++;
        if (cycles == 20000) begin
            num_errors++;
            tally_and_finish();
        end
    end
    ////////////////////////////////////////////////////////////////
    task automatic tally_and_finish();
        if (num_errors == 0 && comparisons > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    task automatic check(string n, logic [15:0] s, logic [15:0] e);
        comparisons++;
        if (s !== e) begin
            num_errors++;
            $display("MISMATCH %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic wr(logic [7:0] a, logic [7:0] d);
        @(posedge ref_clk_i);
        sfr_addr_i <= a;
        sfr_wdata_i <= d;
        sfr_wr_i <= 1'b1;
        @(posedge ref_clk_i);
        sfr_wr_i <= 1'b0;
    endtask
    task automatic rchk(string n, logic [7:0] a, logic [7:0] e);
        @(posedge ref_clk_i);
        sfr_addr_i <= a;
        repeat (2) @(posedge ref_clk_i);
        #1 check(n, 16'(sfr_rdata_o), 16'(e));
    endtask
    // Time counters at their maximum, the selected one optionally at zero
    task automatic preload(int k, logic z);
        for (int i = 0; i < 4; i++) begin
            wr(8'hA2 + 8'(i), (z && i == k) ? 8'h00 : maxv[i]);
        end
    endtask
    ////////////////////////////////////////////////////////////////
    initial begin
        {resetn_i, core_rst_i, sfr_wr_i, sfr_addr_i, sfr_wdata_i} = '0;
        {irq_enable_i, irq_ack_i, power_down_i} = '0;
        repeat (6) @(posedge ref_clk_i);
        resetn_i <= 1'b1;
        repeat (3) @(posedge ref_clk_i);
        rchk("ctrl reset", 8'hA1, 8'h00);
        rchk("unmapped", 8'hA0, 8'h00);
        wr(8'hA1, 8'hC0);
        rchk("ctrl bit7", 8'hA1, 8'h40);
        wr(8'hA6, 8'h5A);
        rchk("match value", 8'hA6, 8'h5A);
        for (int h = 1; h >= 0; h--) begin
            wr(8'hA1, 8'h00);
            preload(0, 1'b0);
            wr(8'hA5, 8'h17);
            wr(8'hA1, h ? 8'h41 : 8'h01);
            repeat (12) @(posedge ref_clk_i);
            rchk("hour wrap", 8'hA5, h ? 8'h00 : 8'h18);
            // Hour sits at 18 here, so a cleared counter would show
            if (h == 0) begin
                wr(8'hA1, 8'h41);
                @(posedge ref_clk_i);
                core_rst_i <= 1'b1;
                @(posedge ref_clk_i);
                core_rst_i <= 1'b0;
                rchk("ctrl core reset", 8'hA1, 8'h01);
                rchk("hour kept", 8'hA5, 8'h18);
            end
        end
        // Repeating interval, match 2, stepped on each subsecond counter wrap
        wr(8'hA1, 8'h00);
        wr(8'hA2, 8'h7F);
        wr(8'hA6, 8'h02);
        wr(8'hA1, 8'h03);
        repeat (300) @(posedge ref_clk_i);
        rchk("one step only", 8'hA1, 8'h03);
        repeat (300) @(posedge ref_clk_i);
        rchk("second step", 8'hA1, 8'h07);
        wr(8'hA1, 8'h03);
        repeat (1100) @(posedge ref_clk_i);
        rchk("reload", 8'hA1, 8'h07);
        @(posedge ref_clk_i);
        irq_enable_i <= 1'b1;
        power_down_i <= 1'b1;
        for (int k = 0; k < 4; k++) begin
            for (int z = 1; z >= 0; z--) begin
                wr(8'hA1, 8'h00);
                preload(k, z[0]);
                wr(8'hA6, 8'h01);
                wr(8'hA1, 8'h0B | {2'b00, 2'(k), 4'h0});
                seen = 1'b0;
                repeat (24) begin
                    @(posedge ref_clk_i);
                    #1 seen = seen | irq_o;
                end
                check("timeout", 16'(seen), 16'(z == 0));
                if (z == 0) begin
                    check("wake", 16'(wake_o), 16'h0001);
                    check("vector", vector_o, 16'h0053);
                    rchk("single shot", 8'hA1, 8'h0D | {2'b00, 2'(k), 4'h0});
                    @(posedge ref_clk_i);
                    irq_ack_i <= 1'b1;
                    @(posedge ref_clk_i);
                    irq_ack_i <= 1'b0;
                    repeat (2) @(posedge ref_clk_i);
                    #1 check("ack", 16'(irq_o), 16'h0000);
                end
            end
        end
        tally_and_finish();
    end
endmodule
